//--- design/fault_retry_defs.vh
// Command codes, field positions, encodings and reset values of the fault response logic
`ifndef FAULT_RETRY_DEFS_VH
`define FAULT_RETRY_DEFS_VH

// ****************************************************************
// Command codes
// ****************************************************************
`define CMD_REACTION        8'h41
`define CMD_THRESHOLD       8'h46

// ****************************************************************
// Reaction register fields
// ****************************************************************
`define MODE_HI             7
`define MODE_LO             6
`define RETRY_HI            5
`define RETRY_LO            3
`define DELAY_HI            2
`define DELAY_LO            0

// ****************************************************************
// Encodings
// ****************************************************************
`define MODE_IGNORE         2'h0
`define MODE_RIDE           2'h1
`define MODE_SHUTDOWN       2'h2
`define MODE_FOLLOW         2'h3
`define RETRY_NONE          3'h0
`define RETRY_FOREVER       3'h7

// ****************************************************************
// Delay field decode, in time units
// ****************************************************************
`define UNITS_0             8'h01
`define UNITS_1             8'h02
`define UNITS_2             8'h04
`define UNITS_3             8'h08
`define UNITS_4             8'h10
`define UNITS_5             8'h20
`define UNITS_6             8'h40
`define UNITS_7             8'h80

// ****************************************************************
// Reset values
// ****************************************************************
`define REACTION_RESET      8'h80
`define THRESHOLD_RESET     16'h0000
`define READ_ZERO_8         8'h00
`define READ_ZERO_16        16'h0000

`endif

//--- design/delay_unit_timer.v
// Delay timer counting decoded time units of a configurable length
`timescale 1ns/100ps
`include "fault_retry_defs.vh"

module delay_unit_timer
#(
   parameter TICK_W = 16
)
(
   input  wire              clock,
   input  wire              rst_b,
   input  wire              ce,
   input  wire              start,
   input  wire [2:0]        code,
   input  wire [TICK_W-1:0] unit_ticks,
   output reg               done
);

   reg  [TICK_W-1:0] tick_reg;
   reg  [7:0]        units_reg;
   reg               busy_reg;

   // ****************************************************************
   // Delay field decode
   // ****************************************************************
   function [7:0] decode_units;
      input [2:0] c;
      begin
         case (c)
            3'h0:    decode_units = `UNITS_0;
            3'h1:    decode_units = `UNITS_1;
            3'h2:    decode_units = `UNITS_2;
            3'h3:    decode_units = `UNITS_3;
            3'h4:    decode_units = `UNITS_4;
            3'h5:    decode_units = `UNITS_5;
            3'h6:    decode_units = `UNITS_6;
            default: decode_units = `UNITS_7;
         endcase
      end
   endfunction

   // ****************************************************************
   // Counters
   // ****************************************************************
   // A zero unit length behaves as one tick so the timer always ends
   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         tick_reg  <= {TICK_W{1'b0}};
         units_reg <= 8'h00;
         busy_reg  <= 1'b0;
         done      <= 1'b0;
      end
      else if (ce)
      begin
         done <= 1'b0;
         if (start)
         begin
            tick_reg  <= unit_ticks;
            units_reg <= decode_units(code) - 8'h01;
            busy_reg  <= 1'b1;
         end
         else if (busy_reg)
         begin
            if (tick_reg > {{(TICK_W-1){1'b0}}, 1'b1})
               tick_reg <= tick_reg - {{(TICK_W-1){1'b0}}, 1'b1};
            else if (units_reg != 8'h00)
            begin
               tick_reg  <= unit_ticks;
               units_reg <= units_reg - 8'h01;
            end
            else
            begin
               busy_reg <= 1'b0;
               done     <= 1'b1;
            end
         end
      end
   end

endmodule

//--- design/reaction_registers.v
// Command-code register file for over-current threshold and reaction
`timescale 1ns/100ps
`include "fault_retry_defs.vh"

module reaction_registers
(
   input  wire        clock,
   input  wire        rst_b,
   input  wire        ce,
   input  wire [7:0]  cmd_code,
   input  wire [15:0] cmd_wdata,
   input  wire        cmd_write,
   input  wire        cmd_read,
   output reg  [15:0] cmd_rdata,
   output reg         cmd_ack,
   output reg         cmd_nack,
   output reg  [7:0]  reaction,
   output reg  [15:0] threshold
);

   // ****************************************************************
   // Storage and read-back
   // ****************************************************************
   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         reaction  <= `REACTION_RESET;
         threshold <= `THRESHOLD_RESET;
         cmd_rdata <= `READ_ZERO_16;
         cmd_ack   <= 1'b0;
         cmd_nack  <= 1'b0;
      end
      else if (ce)
      begin
         cmd_ack  <= 1'b0;
         cmd_nack <= 1'b0;
         if (cmd_write || cmd_read)
         begin
            case (cmd_code)
               `CMD_REACTION:
               begin
                  if (cmd_write)
                     reaction <= cmd_wdata[7:0];
                  cmd_rdata <= {`READ_ZERO_8, reaction};
                  cmd_ack   <= 1'b1;
               end
               `CMD_THRESHOLD:
               begin
                  if (cmd_write)
                     threshold <= cmd_wdata;
                  cmd_rdata <= threshold;
                  cmd_ack   <= 1'b1;
               end
               default:
               begin
                  cmd_rdata <= `READ_ZERO_16;
                  cmd_nack  <= 1'b1;
               end
            endcase
         end
      end
   end

endmodule

//--- design/fault_retry_response.v
// Over-current fault response sequencer with delayed shutdown and retries
// Operation
// - Retry field 4, 5, 6 allows exactly that many restart attempts.
// - After all attempts fail, output stays off until fault cleared.
// - Retry field 7 retries without limit until off command or other fault.
// - Attempt starts spaced by decoded delay count times unit length.
// - Delay field decodes 0..7 to 1,2,4,8,16,32,64,128 units.
// - Ride-through time after fault uses same decoded delay count.
// - Unit length comes from the separate unit configuration value.
// - Threshold held as 16-bit linear value at command 0x46.
// - Reaction held at command 0x41; mode 00 ignores the fault.
// - Mode 01 rides then retries, 10 shuts down, 11 follows fault.
// - Latched fault cleared by bit clear, clear-all, or off/on cycle.
// - Retry field zero means no restart; stay off until cleared.
`timescale 1ns/100ps
`include "fault_retry_defs.vh"

module fault_retry_response
#(
   parameter TICK_W = 16
)
(
   input  wire              clock,
   input  wire              rst_b,
   input  wire              ce,
   input  wire [7:0]        cmd_code,
   input  wire [15:0]       cmd_wdata,
   input  wire              cmd_write,
   input  wire              cmd_read,
   output wire [15:0]       cmd_rdata,
   output wire              cmd_ack,
   output wire              cmd_nack,
   input  wire [TICK_W-1:0] unit_ticks,
   input  wire              oc_fault,
   input  wire              on_request,
   input  wire              other_fault_stop,
   input  wire              clear_faults,
   input  wire              clear_oc_bit,
   output wire [15:0]       output_overcurrent_threshold,
   output reg               output_enable,
   output reg               fault_latched,
   output reg               oc_fault_seen,
   output reg  [2:0]        attempt_count,
   output reg               retrying
);

   // ****************************************************************
   // States
   // ****************************************************************
   // One-hot, so a corrupted code lands in the default branch
   localparam ST_RUN   = 7'h01;
   localparam ST_RIDE  = 7'h02;
   localparam ST_WAIT  = 7'h04;
   localparam ST_TRY   = 7'h08;
   localparam ST_LATCH = 7'h10;
   localparam ST_HOLD  = 7'h20;
   localparam ST_OFF   = 7'h40;

   reg  [6:0]  state_reg;
   reg  [6:0]  state_next;

   reg  [2:0]  attempt_reg;
   reg  [2:0]  attempt_next;

   reg         timer_start;
   reg         out_en_next;
   reg         seen_next;
   wire        timer_done;

   wire [7:0]  output_overcurrent_reaction;
   wire [1:0]  mode;
   wire [2:0]  retries;
   wire [2:0]  delay_code;
   wire        clear_any;

   // Fields are read live, so a rewrite acts on the next decision
   assign mode       = output_overcurrent_reaction[`MODE_HI:`MODE_LO];
   assign retries    = output_overcurrent_reaction[`RETRY_HI:`RETRY_LO];
   assign delay_code = output_overcurrent_reaction[`DELAY_HI:`DELAY_LO];
   assign clear_any  = clear_faults | clear_oc_bit;

   // ****************************************************************
   // Register file and timer
   // ****************************************************************
   reaction_registers u_regs
   (
      .clock     (clock),
      .rst_b     (rst_b),
      .ce        (ce),
      .cmd_code  (cmd_code),
      .cmd_wdata (cmd_wdata),
      .cmd_write (cmd_write),
      .cmd_read  (cmd_read),
      .cmd_rdata (cmd_rdata),
      .cmd_ack   (cmd_ack),
      .cmd_nack  (cmd_nack),
      .reaction  (output_overcurrent_reaction),
      .threshold (output_overcurrent_threshold)
   );

   // A new start reloads the timer and drops any stale count
   delay_unit_timer #(.TICK_W(TICK_W)) u_timer
   (
      .clock      (clock),
      .rst_b      (rst_b),
      .ce         (ce),
      .start      (timer_start),
      .code       (delay_code),
      .unit_ticks (unit_ticks),
      .done       (timer_done)
   );

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   // Attempts are counted when they start, so the limit check on a
   // failed attempt compares the count already including it
   always @*
   begin
      state_next   = state_reg;
      attempt_next = attempt_reg;
      timer_start  = 1'b0;

      if (!on_request)
      begin
         state_next   = ST_OFF;
         attempt_next = 3'h0;
      end

      else if (other_fault_stop && state_reg != ST_OFF)
      begin
         state_next = ST_LATCH;
      end

      else
      begin
         case (state_reg)
            ST_RUN:
            begin
               if (oc_fault)
               begin
                  case (mode)
                     `MODE_IGNORE:
                        state_next = ST_RUN;

                     `MODE_RIDE:
                     begin
                        state_next  = ST_RIDE;
                        timer_start = 1'b1;
                     end

                     `MODE_SHUTDOWN:
                     begin
                        attempt_next = 3'h0;
                        if (retries == `RETRY_NONE)
                           state_next = ST_LATCH;
                        else
                        begin
                           state_next  = ST_WAIT;
                           timer_start = 1'b1;
                        end
                     end

                     default:
                        state_next = ST_HOLD;
                  endcase
               end
            end

            ST_RIDE:
            begin
               if (timer_done)
               begin
                  attempt_next = 3'h0;
                  if (!oc_fault)
                     state_next = ST_RUN;

                  else if (retries == `RETRY_NONE)
                     state_next = ST_LATCH;
                  else
                  begin
                     state_next  = ST_WAIT;
                     timer_start = 1'b1;
                  end
               end
            end

            ST_WAIT:
            begin
               if (timer_done)
               begin
                  state_next  = ST_TRY;
                  timer_start = 1'b1;

                  if (retries != `RETRY_FOREVER)
                     attempt_next = attempt_reg + 3'h1;
               end
            end

            // A fault ends the attempt at once; the running timer keeps
            // the start-to-start spacing
            ST_TRY:
            begin
               if (oc_fault)
               begin
                  if (retries != `RETRY_FOREVER && attempt_reg >= retries)
                     state_next = ST_LATCH;
                  else
                  begin
                     state_next  = ST_WAIT;
                     timer_start = timer_done;
                  end
               end
               else if (timer_done)
               begin
                  state_next   = ST_RUN;
                  attempt_next = 3'h0;
               end
            end

            // Only a clear or an off request leaves; a fault still present is met in run
            ST_LATCH:
            begin
               if (clear_any)
               begin
                  state_next   = ST_RUN;
                  attempt_next = 3'h0;
               end
            end

            ST_HOLD:
            begin
               if (!oc_fault)
                  state_next = ST_RUN;
            end

            // The off and on cycle also clears a latched fault
            ST_OFF:
            begin
               state_next = ST_RUN;
            end

            default:
            begin
               state_next   = ST_OFF;
               attempt_next = 3'h0;
            end
         endcase
      end
   end

   // ****************************************************************
   // Output and status decode
   // ****************************************************************
   // Sticky status: a new fault in the clearing cycle keeps the bit set
   always @*
   begin
      out_en_next = 1'b0;
      case (state_next)
         ST_RUN:  out_en_next = 1'b1;
         ST_RIDE: out_en_next = 1'b1;
         ST_TRY:  out_en_next = 1'b1;
         default: out_en_next = 1'b0;
      endcase

      seen_next = oc_fault_seen;
      if (clear_any)
         seen_next = 1'b0;
      if (oc_fault)
         seen_next = 1'b1;
   end

   // ****************************************************************
   // State registers
   // ****************************************************************
   always @(posedge clock or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_reg     <= ST_OFF;
         attempt_reg   <= 3'h0;

         output_enable <= 1'b0;
         fault_latched <= 1'b0;
         oc_fault_seen <= 1'b0;
         attempt_count <= 3'h0;
         retrying      <= 1'b0;
      end

      else if (ce)
      begin
         state_reg     <= state_next;
         attempt_reg   <= attempt_next;

         output_enable <= out_en_next;
         fault_latched <= (state_next == ST_LATCH);
         oc_fault_seen <= seen_next;
         attempt_count <= attempt_next;
         retrying      <= (state_next == ST_WAIT) || (state_next == ST_TRY);
      end
   end

endmodule

//--- sim/fault_retry_asserts.sv
// Port-level concurrent checks of the fault response sequencer
`timescale 1ns/100ps
`include "fault_retry_defs.vh"
module fault_retry_asserts
#(
   parameter TICK_W = 16
)
(
   input wire logic              clock,
   input wire logic              rst_b,
   input wire logic              ce,
   input wire logic [7:0]        cmd_code,
   input wire logic [15:0]       cmd_wdata,
   input wire logic              cmd_write,
   input wire logic              cmd_read,
   input wire logic [15:0]       cmd_rdata,
   input wire logic              cmd_ack,
   input wire logic              cmd_nack,
   input wire logic [TICK_W-1:0] unit_ticks,
   input wire logic              oc_fault,
   input wire logic              on_request,
   input wire logic              other_fault_stop,
   input wire logic              clear_faults,
   input wire logic              clear_oc_bit,
   input wire logic [15:0]       output_overcurrent_threshold,
   input wire logic              output_enable,
   input wire logic              fault_latched,
   input wire logic [2:0]        attempt_count,
   input wire logic              retrying
);
   // ****************************************************************
   // Shadow of the reaction byte, as the checker sees only the ports
   // ****************************************************************
   logic [7:0] reaction_reg;
   wire        mapped = cmd_code == `CMD_REACTION || cmd_code == `CMD_THRESHOLD;
   wire        steady = ce && on_request && !other_fault_stop && output_enable && !retrying
                        && !fault_latched;
   always @(posedge clock or negedge rst_b)
      if (!rst_b)
         reaction_reg <= `REACTION_RESET;
      else if (ce && cmd_write && cmd_code == `CMD_REACTION)
         reaction_reg <= cmd_wdata[7:0];
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   a_access_ack: assert property (ce && (cmd_write || cmd_read) && mapped |=> cmd_ack && !cmd_nack)
      else $error("mapped access not acknowledged");
   a_unmapped_nack: assert property (ce && cmd_read && !cmd_write && !mapped
      |=> cmd_nack && !cmd_ack && cmd_rdata == 16'h0000) else $error("unmapped read not refused");
   a_limit_store: assert property (ce && cmd_write && cmd_code == `CMD_THRESHOLD
      |=> output_overcurrent_threshold == $past(cmd_wdata)) else $error("threshold not stored");
   a_ignore_keeps: assert property (steady && reaction_reg[7:6] == `MODE_IGNORE |=> output_enable)
      else $error("ignored fault dropped output");
   a_stop_shuts: assert property (steady && oc_fault && reaction_reg[7] |=> !output_enable)
      else $error("fault did not shut output");
   a_ride_on: assert property (steady && $rose(oc_fault) && reaction_reg[7:6] == `MODE_RIDE
      |=> output_enable ##1 output_enable) else $error("ride-through cut short");
   a_off_request: assert property (ce && !on_request |=> !output_enable && !fault_latched)
      else $error("off command ignored");
   a_other_latch: assert property (ce && on_request && other_fault_stop
      |=> !output_enable && fault_latched) else $error("other fault did not latch");
   a_latch_holds: assert property (fault_latched && ce && on_request && !clear_faults
      && !clear_oc_bit |=> fault_latched && !output_enable) else $error("latch released");
   a_clear_release: assert property (fault_latched && ce && on_request && !other_fault_stop
      && (clear_faults || clear_oc_bit) |=> !fault_latched && output_enable)
      else $error("clear did not restart");
   a_count_bound: assert property (retrying && reaction_reg[5:3] != `RETRY_FOREVER
      |-> attempt_count <= reaction_reg[5:3]) else $error("too many restarts");
   a_forever_zero: assert property (retrying && reaction_reg[5:3] == `RETRY_FOREVER
      |-> attempt_count == 3'h0) else $error("unlimited retry counted");
   c_six_tries: cover property (fault_latched && attempt_count == 3'h6);
   c_forever: cover property ($rose(output_enable) && retrying);
   c_refused: cover property (cmd_nack);
endmodule
bind fault_retry_response fault_retry_asserts #(.TICK_W(TICK_W)) checker_inst
(
   .clock(clock), .rst_b(rst_b), .ce(ce), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
   .cmd_write(cmd_write), .cmd_read(cmd_read), .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack),
   .cmd_nack(cmd_nack), .unit_ticks(unit_ticks), .oc_fault(oc_fault), .on_request(on_request),
   .other_fault_stop(other_fault_stop), .clear_faults(clear_faults),
   .clear_oc_bit(clear_oc_bit), .output_overcurrent_threshold(output_overcurrent_threshold),
   .output_enable(output_enable), .fault_latched(fault_latched),
   .attempt_count(attempt_count), .retrying(retrying)
);

//--- sim/host_model.sv
// Management host issuing command strobes and fault clears
`timescale 1ns/100ps
module host_model
(
   input  wire logic   clock,
   output logic [7:0]  cmd_code,
   output logic [15:0] cmd_wdata,
   output logic        cmd_write,
   output logic        cmd_read,
   output logic        clear_faults,
   output logic        clear_oc_bit
);
   initial
   begin
      cmd_code = 8'h00;
      cmd_wdata = 16'h0000;
      cmd_write = 1'b0;
      cmd_read = 1'b0;
      clear_faults = 1'b0;
      clear_oc_bit = 1'b0;
   end
   // One strobe cycle; released lines turn over so stale values cannot pass
   task access(input logic w, input logic [7:0] c, input logic [15:0] d);
      @(posedge clock);
      cmd_code <= c;
      cmd_wdata <= d;
      cmd_write <= w;
      cmd_read <= !w;
      @(posedge clock);
      cmd_write <= 1'b0;
      cmd_read <= 1'b0;
      cmd_code <= ~c;
      cmd_wdata <= ~d;
   endtask
   task clear(input logic bit_only);
      @(posedge clock);
      if (bit_only)
         clear_oc_bit <= 1'b1;
      else
         clear_faults <= 1'b1;
      @(posedge clock);
      clear_oc_bit <= 1'b0;
      clear_faults <= 1'b0;
   endtask
endmodule

//--- sim/test_fault_retry_response.sv
// Self-checking bench for the fault response sequencer
`timescale 1ns/100ps
`include "fault_retry_defs.vh"
module test_fault_retry_response;
   logic        clock;
   logic        rst_b;
   logic        ce;
   logic [15:0] unit_ticks;
   logic        oc_fault;
   logic        on_request;
   logic        other_fault_stop;
   wire  [7:0]  cmd_code;
   wire  [15:0] cmd_wdata;
   wire  [15:0] cmd_rdata;
   wire         cmd_write, cmd_read, cmd_ack, cmd_nack, clear_faults, clear_oc_bit;
   wire         output_enable, fault_latched, oc_fault_seen, retrying;
   wire  [2:0]  attempt_count;
   logic [17:0] notes[$];
   logic [17:0] note;
   logic [15:0] rnd;
   int          err_total, checked, cycles, n, rises, gap, ticks, base;
   host_model host (.clock(clock), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
      .cmd_write(cmd_write), .cmd_read(cmd_read), .clear_faults(clear_faults),
      .clear_oc_bit(clear_oc_bit));
   fault_retry_response #(.TICK_W(16)) DUT (.clock(clock), .rst_b(rst_b), .ce(ce),
      .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_write(cmd_write), .cmd_read(cmd_read),
      .cmd_rdata(cmd_rdata), .cmd_ack(cmd_ack), .cmd_nack(cmd_nack), .unit_ticks(unit_ticks),
      .oc_fault(oc_fault), .on_request(on_request), .other_fault_stop(other_fault_stop),
      .clear_faults(clear_faults), .clear_oc_bit(clear_oc_bit),
      .output_overcurrent_threshold(), .output_enable(output_enable),
      .fault_latched(fault_latched), .oc_fault_seen(oc_fault_seen),
      .attempt_count(attempt_count), .retrying(retrying));
   always #20 clock = ~clock;
   // ****************************************************************
   // Checking and closing
   // ****************************************************************
   task chk(input logic ok, input string what);
      checked = checked + 1;
      if (ok !== 1'b1)
      begin
         err_total = err_total + 1;
         $display("unexpected at %0t: %s", $time, what);
      end
   endtask
   task close_out;
      if (err_total == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Each answer takes the oldest note; an answer with no note always mismatches
   always @(posedge clock)
   begin
      cycles = cycles + 1;
      if (cycles == 20000)
      begin
         err_total = err_total + 1;
         close_out;
      end
      if (cmd_ack === 1'b1 || cmd_nack === 1'b1)
      begin
         note = notes.size() ? notes.pop_front() : {1'b1, ~cmd_nack, ~cmd_rdata};
         chk(cmd_nack === note[16] && (!note[17] || cmd_rdata === note[15:0]), "answer");
      end
   end
   task reg_op(input logic w, input logic [7:0] c, input logic [15:0] d, input logic [16:0] e);
      notes.push_back({!w, e});
      host.access(w, c, d);
   endtask
   task set_reaction(input logic [1:0] m, input logic [2:0] r, input logic [2:0] k);
      rnd = $urandom;
      reg_op(1'b1, `CMD_REACTION, {rnd[15:8], m, r, k}, 17'h00000);
      reg_op(1'b0, `CMD_REACTION, 16'h0000, {9'h000, m, r, k});
   endtask
   // Counts restarts (rising output) until latched, or times the gap of two restarts
   task watch(input logic to_latch);
      int   t;
      logic last;
      last = output_enable;
      rises = 0;
      gap = 0;
      for (t = 0; t < 3000 && (to_latch ? fault_latched !== 1'b1 : rises < 2); t++)
      begin
         @(posedge clock);
         if (output_enable === 1'b1 && last !== 1'b1)
         begin
            rises++;
            gap = t - gap;
         end
         last = output_enable;
      end
   endtask
   task release_latch(input int how);
      if (how < 2)
         host.clear(how[0]);
      else
      begin
         @(posedge clock);
         on_request <= 1'b0;
         @(posedge clock);
         on_request <= 1'b1;
      end
      repeat (3) @(posedge clock);
      chk(output_enable === 1'b1 && fault_latched === 1'b0, "restart after clear");
   endtask
   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial
   begin
      clock = 1'b0;
      rst_b = 1'b0;
      ce = 1'b1;
      unit_ticks = 16'h0001;
      oc_fault = 1'b0;
      on_request = 1'b1;
      other_fault_stop = 1'b0;
      err_total = 0;
      checked = 0;
      cycles = 0;
      void'($urandom(32'h6D7A));
      repeat (12) @(posedge clock);
      rst_b <= 1'b1;
      rnd = $urandom;
      reg_op(1'b0, `CMD_REACTION, 16'h0000, {9'h000, `REACTION_RESET});
      reg_op(1'b0, `CMD_THRESHOLD, 16'h0000, {1'b0, `THRESHOLD_RESET});
      reg_op(1'b1, `CMD_THRESHOLD, rnd, 17'h00000);
      reg_op(1'b1, 8'hD2, ~rnd, 17'h10000);
      reg_op(1'b0, 8'hD2, 16'h0000, 17'h10000);
      reg_op(1'b0, `CMD_THRESHOLD, 16'h0000, {1'b0, rnd});
      for (n = 0; n < 7; n++)
      begin
         set_reaction(`MODE_SHUTDOWN, n[2:0], 3'h0);
         oc_fault <= 1'b1;
         watch(1'b1);
         chk(rises == n, "restart count");
         repeat (20) @(posedge clock);
         chk(output_enable === 1'b0 && fault_latched === 1'b1, "latched off");
         oc_fault <= 1'b0;
         release_latch(n % 3);
      end
      for (n = 0; n < 8; n++)
      begin
         ticks = 1 + $urandom % 3;
         unit_ticks <= ticks[15:0];
         set_reaction(`MODE_SHUTDOWN, `RETRY_FOREVER, n[2:0]);
         oc_fault <= 1'b1;
         watch(1'b0);
         if (n == 0)
            base = gap - ticks;
         chk(gap - (ticks << n) == base && base >= 0 && base < 5, "spacing");
         chk(attempt_count === 3'h0 && retrying === 1'b1, "unlimited retry");
         on_request <= 1'b0;
         oc_fault <= 1'b0;
         repeat (2) @(posedge clock);
         chk(output_enable === 1'b0, "off command stops retries");
         on_request <= 1'b1;
         repeat (3) @(posedge clock);
      end
      unit_ticks <= 16'h0002;
      oc_fault <= 1'b1;
      repeat (10) @(posedge clock);
      other_fault_stop <= 1'b1;
      @(posedge clock);
      other_fault_stop <= 1'b0;
      oc_fault <= 1'b0;
      repeat (3) @(posedge clock);
      chk(fault_latched === 1'b1 && output_enable === 1'b0, "other fault stops");
      release_latch(0);
      set_reaction(`MODE_RIDE, `RETRY_NONE, 3'h2);
      oc_fault <= 1'b1;
      repeat (9) @(posedge clock);
      chk(output_enable === 1'b1, "rides through delay");
      repeat (4) @(posedge clock);
      chk(fault_latched === 1'b1 && output_enable === 1'b0, "off after ride");
      oc_fault <= 1'b0;
      release_latch(1);
      set_reaction(`MODE_IGNORE, 3'h4, 3'h0);
      oc_fault <= 1'b1;
      repeat (40) @(posedge clock);
      chk(output_enable === 1'b1 && oc_fault_seen === 1'b1, "fault ignored");
      set_reaction(`MODE_FOLLOW, 3'h4, 3'h0);
      chk(output_enable === 1'b0 && fault_latched === 1'b0, "off while fault");
      oc_fault <= 1'b0;
      repeat (3) @(posedge clock);
      chk(output_enable === 1'b1, "on when fault gone");
      host.clear(1'b1);
      repeat (2) @(posedge clock);
      chk(oc_fault_seen === 1'b0 && notes.size() == 0, "status cleared");
      close_out;
   end
endmodule
